// ### design/cas_defs.vh
`ifndef CAS_DEFS_VH
`define CAS_DEFS_VH

// Command byte: read flag in bit 7, register address in bits 6..0
`define CAS_CMD_RW_BIT      7
`define CAS_ADDR_PHASE      7'h40
`define CAS_ADDR_RATE       7'h50
`define CAS_ADDR_CFG        7'h60
`define CAS_ADDR_DATA       7'h70

// Register widths, which are also the transfer lengths per device
`define CAS_LEN_PHASE       7'd32
`define CAS_LEN_RATE        7'd16
`define CAS_LEN_CFG         7'd8
`define CAS_LEN_DATA        7'd96

// Reset values
`define CAS_PHASE_RST       32'h00000000
`define CAS_RATE_RST        16'h0000
`define CAS_CFG_RST         8'h00

// Configuration field positions
`define CAS_CFG_SHDN        7
`define CAS_CFG_RESET       6
`define CAS_CFG_EN24        5
`define CAS_CFG_XTALEN      4
`define CAS_CFG_FAULTDIS    3
`define CAS_CFG_PDBUF       2
`define CAS_CFG_WMASK       8'hFC

// Master-clock cycles per phase count, as a shift, and the phase field width
`define CAS_PHASE_SHIFT     5
`define CAS_PHASE_W         8

// Conversion result FIFO
`define CAS_FIFO_DEPTH      4
`define CAS_FIFO_AW         2

`endif

// ### design/cas_fifo.v
`timescale 1ns/1ps
module cas_fifo #(
  parameter W  = 96,
  parameter D  = 4,
  parameter AW = 2
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Fill side
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output wire          in_ready,
  // Drain side
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0]   cnt_reg;
  reg          room_reg;
  wire         push;
  wire         pop;
  wire [AW:0]  cnt_next;

  assign push      = in_valid & room_reg;
  assign pop       = out_valid & out_ready;
  assign in_ready  = room_reg;
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_reg];
  assign cnt_next  = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_reg   <= {AW{1'b0}};
      rd_reg   <= {AW{1'b0}};
      cnt_reg  <= {(AW+1){1'b0}};
      room_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == D-1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == D-1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      cnt_reg  <= cnt_next;
      room_reg <= (cnt_next != D);
    end
  end
endmodule // cas_fifo

// ### design/cas_phase.v
`timescale 1ns/1ps
`include "cas_defs.vh"
module cas_phase (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Master-clock tick and controls
  input  wire        xin_tick,
  input  wire        realign,
  input  wire [15:0] rate,
  input  wire [31:0] phase,
  // Sampling strobes
  output reg  [3:0]  sample_reg
);
  reg  [15:0] cnt_reg;

  function [15:0] delay_of;
    input [`CAS_PHASE_W-1:0] ph;
    begin
      delay_of = {3'h0, ph, 5'h00};
    end
  endfunction

  always @(posedge clk) begin
    if (rst || realign) begin
      cnt_reg    <= 16'h0000;
      sample_reg <= 4'h0;
    end else begin
      sample_reg <= 4'h0;
      if (xin_tick) begin
        cnt_reg <= (cnt_reg >= rate) ? 16'h0000 : cnt_reg + 16'h0001;
        // Channel 0 sits in the top byte, channel 3 in the bottom
        sample_reg[0] <= (cnt_reg == delay_of(phase[31:24]));
        sample_reg[1] <= (cnt_reg == delay_of(phase[23:16]));
        sample_reg[2] <= (cnt_reg == delay_of(phase[15:8]));
        sample_reg[3] <= (cnt_reg == delay_of(phase[7:0]));
      end
    end
  end
endmodule // cas_phase

// ### design/cas_port.v
// Notes on behaviour
// - Clock idles high, first edge captures data
// - Phase 32, rate 16, config 8, data 96
// - Command: read flag MSB, seven-bit address
// - Input bit captured on serial clock fall
// - Output bit changes on serial clock rise
// - Both directions shift most significant bit first
// - Chip select high: ignore, output off
// - Operation takes effect at last rise
// - Early deselect discards the partial write
// - Upstream ready low: fall on fresh data
// - Chain enable and ready pins allow daisy-chaining
// - Phase, rate, config addresses read and write
// - Data register read-only, 96 bits each
// - Phase and config lengths scale per device
// - Rate always 16 bits, all devices
// - Default phase zero samples channels together
// - Each phase count delays 32 cycles
// - Channel 0 top byte, channel 3 bottom
// - Config holds six bits, resets to zero
// - Config reset bit restores others, realigns
// - Unread results are overwritten by new ones
`timescale 1ns/1ps
`include "cas_defs.vh"
module cas_port #(
  parameter DW = 96
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Serial pins
  input  wire          cs_n,
  input  wire          sclk,
  input  wire          din,
  output reg           dout_reg,
  output reg           dout_oe_reg,
  // Cascade pins
  input  wire          chain_enable_in,
  output reg           chain_enable_out,
  input  wire          upstream_ready_n_in,
  output reg           ready_n_out,
  // Master clock pin
  input  wire          master_clock_in,
  // Conversion results from the core
  input  wire          conv_valid,
  input  wire [DW-1:0] conv_data,
  output wire          conv_ready,
  // Core controls
  output reg  [7:0]    config_out,
  output reg  [15:0]   rate_out,
  output wire [3:0]    ch_sample
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_CMD  = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_SKIP = 4'b1000;

  // Pin synchronisers
  reg  [4:0]    s1_reg;
  reg  [4:0]    s2_reg;
  reg           sclk_d_reg;
  reg           xin_d_reg;
  wire          cs_s;
  wire          sclk_s;
  wire          din_s;
  wire          chain_s;
  wire          up_s;
  wire          fall;
  wire          rise;
  reg  [1:0]    x1_reg;

  // Transfer state
  reg  [3:0]    state_reg;
  reg  [6:0]    bit_reg;
  reg  [6:0]    cmd_reg;
  reg           rw_reg;
  reg  [3:0]    sel_reg;
  reg  [6:0]    len_reg;
  reg           done_reg;
  reg           pend_reg;
  reg  [31:0]   in_reg;
  reg  [DW-1:0] out_reg;
  wire          active;
  wire [7:0]    cmd_byte;

  // Registers
  reg  [31:0]   phase_reg;
  reg  [15:0]   rate_reg;
  reg  [7:0]    cfg_reg;
  reg  [DW-1:0] data_reg;
  reg           fresh_reg;
  reg           realign_reg;
  reg           xin_tick_reg;
  wire          f_valid;
  wire [DW-1:0] f_data;
  wire          f_pop;
  wire          reading_data;

  assign cs_s     = s2_reg[0];
  assign sclk_s   = s2_reg[1];
  assign din_s    = s2_reg[2];
  assign chain_s  = s2_reg[3];
  assign up_s     = s2_reg[4];
  assign fall     = sclk_d_reg & ~sclk_s;
  assign rise     = ~sclk_d_reg & sclk_s;
  assign cmd_byte = {cmd_reg, din_s};
  // Rate is shared by the whole chain; other registers wait their turn
  assign active   = ~chain_s | sel_reg[1];

  assign reading_data = state_reg[2] & sel_reg[3];
  // Results wait in the FIFO while the data register is being read
  assign f_pop = f_valid & ~reading_data;

  // Decode length of a command, zero when it is not accepted
  function [6:0] len_of;
    input [7:0] c;
    begin
      case (c[6:0])
        `CAS_ADDR_PHASE: len_of = `CAS_LEN_PHASE;
        `CAS_ADDR_RATE:  len_of = `CAS_LEN_RATE;
        `CAS_ADDR_CFG:   len_of = `CAS_LEN_CFG;
        `CAS_ADDR_DATA:  len_of = c[`CAS_CMD_RW_BIT] ? `CAS_LEN_DATA : 7'd0;
        default:         len_of = 7'd0;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (rst) begin
      s1_reg     <= 5'h1F;
      s2_reg     <= 5'h1F;
      sclk_d_reg <= 1'b1;
      x1_reg     <= 2'h0;
      xin_d_reg  <= 1'b0;
    end else begin
      s1_reg     <= {upstream_ready_n_in, chain_enable_in, din, sclk, cs_n};
      s2_reg     <= s1_reg;
      sclk_d_reg <= sclk_s;
      x1_reg     <= {x1_reg[0], master_clock_in};
      xin_d_reg  <= x1_reg[1];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      xin_tick_reg <= 1'b0;
    end else begin
      xin_tick_reg <= x1_reg[1] & ~xin_d_reg;
    end
  end

  // Serial transfer engine
  always @(posedge clk) begin
    if (rst || cs_s) begin
      state_reg        <= ST_IDLE;
      bit_reg          <= 7'd0;
      cmd_reg          <= 7'd0;
      rw_reg           <= 1'b0;
      sel_reg          <= 4'h0;
      len_reg          <= 7'd0;
      done_reg         <= 1'b0;
      pend_reg         <= 1'b0;
      in_reg           <= 32'h00000000;
      out_reg          <= {DW{1'b0}};
      dout_reg         <= 1'b0;
      dout_oe_reg      <= 1'b0;
      chain_enable_out <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_CMD;
          bit_reg   <= 7'd0;
        end
        ST_CMD: begin
          if (fall) begin
            cmd_reg <= {cmd_reg[5:0], din_s};
            bit_reg <= bit_reg + 7'd1;
            if (bit_reg == 7'd7) begin
              bit_reg <= 7'd0;
              rw_reg  <= cmd_byte[`CAS_CMD_RW_BIT];
              len_reg <= len_of(cmd_byte);
              sel_reg <= {cmd_byte[6:0] == `CAS_ADDR_DATA,
                          cmd_byte[6:0] == `CAS_ADDR_CFG,
                          cmd_byte[6:0] == `CAS_ADDR_RATE,
                          cmd_byte[6:0] == `CAS_ADDR_PHASE};
              case (cmd_byte[6:0])
                `CAS_ADDR_PHASE: out_reg <= {phase_reg, 64'h0};
                `CAS_ADDR_RATE:  out_reg <= {rate_reg, 80'h0};
                `CAS_ADDR_CFG:   out_reg <= {cfg_reg, 88'h0};
                default:         out_reg <= data_reg;
              endcase
              if (len_of(cmd_byte) == 7'd0) begin
                state_reg <= ST_SKIP;
              end else begin
                state_reg <= ST_DATA;
              end
            end
          end
        end
        ST_DATA: begin
          if (fall && active && !done_reg) begin
            in_reg  <= {in_reg[30:0], din_s};
            bit_reg <= bit_reg + 7'd1;
            if (bit_reg == len_reg - 7'd1) begin
              done_reg <= 1'b1;
              pend_reg <= ~rw_reg;
            end
          end
          if (rise) begin
            dout_oe_reg <= rw_reg & active & ~done_reg;
            if (rw_reg && active && !done_reg) begin
              dout_reg <= out_reg[DW-1];
              out_reg  <= {out_reg[DW-2:0], 1'b0};
            end
            if (pend_reg) begin
              pend_reg <= 1'b0;
            end
            if (done_reg && !sel_reg[1]) begin
              chain_enable_out <= 1'b0;
            end
          end
        end
        ST_SKIP: begin
          dout_oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Register file, written only at the last rising edge of a full write
  always @(posedge clk) begin
    if (rst) begin
      phase_reg   <= `CAS_PHASE_RST;
      rate_reg    <= `CAS_RATE_RST;
      cfg_reg     <= `CAS_CFG_RST;
      realign_reg <= 1'b0;
    end else begin
      realign_reg <= 1'b0;
      if (!cs_s && state_reg[2] && rise && pend_reg) begin
        if (sel_reg[0]) begin
          phase_reg <= in_reg;
        end
        if (sel_reg[1]) begin
          rate_reg <= in_reg[15:0];
        end
        if (sel_reg[2]) begin
          if (in_reg[`CAS_CFG_RESET]) begin
            phase_reg   <= `CAS_PHASE_RST;
            rate_reg    <= `CAS_RATE_RST;
            cfg_reg     <= `CAS_CFG_RST | (8'h01 << `CAS_CFG_RESET);
            realign_reg <= 1'b1;
          end else begin
            cfg_reg <= in_reg[7:0] & `CAS_CFG_WMASK;
          end
        end
      end
    end
  end

  // Conversion results and data-ready
  always @(posedge clk) begin
    if (rst || realign_reg) begin
      data_reg    <= {DW{1'b0}};
      fresh_reg   <= 1'b0;
      ready_n_out <= 1'b1;
    end else begin
      if (f_pop) begin
        data_reg    <= f_data;
        fresh_reg   <= 1'b1;
        ready_n_out <= 1'b1;
      end else if (fresh_reg && !up_s) begin
        fresh_reg   <= 1'b0;
        ready_n_out <= 1'b0;
      end else if (reading_data) begin
        ready_n_out <= 1'b1;
      end
    end
  end

  // Controls handed to the core, one register stage behind the file
  always @(posedge clk) begin
    if (rst) begin
      config_out <= `CAS_CFG_RST;
      rate_out   <= `CAS_RATE_RST;
    end else begin
      config_out <= cfg_reg;
      rate_out   <= rate_reg;
    end
  end

  cas_fifo #(
    .W  (DW),
    .D  (`CAS_FIFO_DEPTH),
    .AW (`CAS_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (conv_valid),
    .in_data   (conv_data),
    .in_ready  (conv_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (~reading_data)
  );

  cas_phase u_phase (
    .clk        (clk),
    .rst        (rst),
    .xin_tick   (xin_tick_reg),
    .realign    (realign_reg),
    .rate       (rate_out),
    .phase      (phase_reg),
    .sample_reg (ch_sample)
  );
endmodule // cas_port

// ### sim/cas_port_sva.sv
`timescale 1ns/1ps
module cas_port_sva (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Serial and cascade pins
  input wire        cs_n,
  input wire        sclk,
  input wire        dout_reg,
  input wire        dout_oe_reg,
  input wire        chain_enable_out,
  input wire        upstream_ready_n_in,
  input wire        ready_n_out,
  // Core controls
  input wire [7:0]  config_out,
  input wire [15:0] rate_out,
  input wire [3:0]  ch_sample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle;
    cs_n [*6];
  endsequence
  sequence s_quiet;
    cs_n [*4];
  endsequence
  a_rst_vals: assert property (disable iff (1'b0) rst |=>
    ready_n_out && chain_enable_out && !dout_oe_reg && config_out == 8'h00
    && rate_out == 16'h0000) else $error("reset values wrong");
  a_oe_idle: assert property (s_idle |-> !dout_oe_reg)
    else $error("output driven while deselected");
  a_oe_end: assert property ($rose(cs_n) |-> ##[0:5] !dout_oe_reg)
    else $error("output not released");
  a_oe_start: assert property ($rose(dout_oe_reg) |-> !cs_n && !$past(cs_n, 3))
    else $error("output driven without select");
  a_dout_rise: assert property ($changed(dout_reg) && $past(dout_oe_reg) |-> $past(sclk, 2))
    else $error("output bit moved off a rise");
  a_idle_hold: assert property (s_quiet |=> $stable(rate_out) && $stable(config_out))
    else $error("register moved while deselected");
  a_write_sel: assert property ($changed(rate_out) || $changed(config_out) |-> !$past(cs_n, 2))
    else $error("register moved outside transfer");
  a_cfg_resv: assert property (config_out[1:0] == 2'h0)
    else $error("reserved config bits set");
  a_ready_src: assert property ($fell(ready_n_out) |-> !$past(upstream_ready_n_in, 3))
    else $error("ready fell with upstream high");
  a_chain_sel: assert property ($fell(chain_enable_out) |-> !cs_n)
    else $error("chain enable fell outside transfer");
  a_sample_one: assert property (|ch_sample |=> ch_sample == 4'h0)
    else $error("sample strobe too long");
endmodule // cas_port_sva
bind cas_port cas_port_sva cas_port_sva_i (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
  .dout_reg(dout_reg), .dout_oe_reg(dout_oe_reg), .chain_enable_out(chain_enable_out),
  .upstream_ready_n_in(upstream_ready_n_in), .ready_n_out(ready_n_out),
  .config_out(config_out), .rate_out(rate_out), .ch_sample(ch_sample));

// ### sim/cas_host.sv
`timescale 1ns/1ps
module cas_host (
  // Serial pins
  output reg  cs_n,
  output reg  sclk,
  output reg  din,
  input  wire dout,
  input  wire dout_oe
);
  // Released line shows no stale bit
  wire dl = dout_oe ? dout : ~dout;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end
  // One framed transfer; cut above zero deselects after that many data bits
  task xfer(input [7:0] cmd, input integer n, input [95:0] wd, input integer cut,
            output [95:0] rd);
    integer     i;
    reg [103:0] sh;
    begin
      sh = {cmd, wd << (96 - n)};
      rd = 96'h0;
      #7 cs_n = 1'b0;
      #100;
      for (i = 0; i < 8 + n && (cut == 0 || i < 8 + cut); i = i + 1) begin
        din = sh[103 - i];
        #100 sclk = 1'b0;
        if (i >= 8) rd = {rd[94:0], dl};
        #100 sclk = 1'b1;
      end
      #100 cs_n = 1'b1;
      din = ~din;
      #100;
    end
  endtask
endmodule // cas_host

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         upstream_ready_n_in = 1'b0;
  reg         master_clock_in = 1'b0;
  reg         conv_valid = 1'b0;
  reg  [95:0] conv_data = 96'h0;
  reg  [1:0]  mck = 2'h0;
  reg  [95:0] rd, m_reg [0:2], q [$];
  wire        cs_n, sclk, din, dout_reg, dout_oe_reg, conv_ready;
  wire        chain_enable_out, ready_n_out;
  wire [7:0]  config_out;
  wire [15:0] rate_out;
  wire [3:0]  ch_sample;
  integer     n_errors = 0, num_checks = 0, i, k;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    mck <= mck + 2'h1;
    master_clock_in <= mck[1];
  end
  cas_port cas_port_i (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_reg(dout_reg), .dout_oe_reg(dout_oe_reg), .chain_enable_in(1'b0),
    .chain_enable_out(chain_enable_out), .upstream_ready_n_in(upstream_ready_n_in),
    .ready_n_out(ready_n_out), .master_clock_in(master_clock_in), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .config_out(config_out),
    .rate_out(rate_out), .ch_sample(ch_sample));
  cas_host cas_host_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_reg),
    .dout_oe(dout_oe_reg));
  function [6:0] adr(input integer r);
    adr = {1'b1, r[1:0], 4'h0};
  endfunction
  function integer len(input integer r);
    len = (r == 3) ? 96 : 32 >> r;
  endfunction
  task chk(input [95:0] got, input [95:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input integer r, input [95:0] v);
    cas_host_i.xfer({1'b0, adr(r)}, len(r), v, 0, rd);
  endtask
  task rdchk(input integer r, input [95:0] e);
    begin
      cas_host_i.xfer({1'b1, adr(r)}, len(r), 96'h0, 0, rd);
      chk(rd, e);
    end
  endtask
  task push;
    begin
      @(posedge clk);
      conv_data  <= {$urandom, $urandom, $urandom};
      conv_valid <= 1'b1;
      @(negedge clk);
      for (k = 0; k < 5000 && !conv_ready; k = k + 1) @(negedge clk);
      @(posedge clk);
      q.push_back(conv_data);
      conv_valid <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wait_ready;
    for (k = 0; k < 400 && ready_n_out; k = k + 1) @(posedge clk);
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    k = $urandom(81);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({config_out, rate_out, ready_n_out, chain_enable_out}, 26'h0000003);
    rdchk(0, 96'h0);
    for (i = 0; i < 3; i = i + 1) begin
      m_reg[i] = {$urandom, $urandom, $urandom} & ((96'h1 << len(i)) - 96'h1);
      if (i == 2) m_reg[i] = m_reg[i] & 96'h3C;
      wr(i, m_reg[i]);
    end
    for (i = 0; i < 3; i = i + 1) rdchk(i, m_reg[i]);
    chk({config_out, rate_out}, {m_reg[2][7:0], m_reg[1][15:0]});
    cas_host_i.xfer(8'h40, 32, ~m_reg[0], 20, rd);
    rdchk(0, m_reg[0]);
    cas_host_i.xfer(8'h70, 16, 96'h5A5A, 0, rd);
    cas_host_i.xfer(8'h51, 16, 96'hA5A5, 0, rd);
    rdchk(1, m_reg[1]);
    push;
    wait_ready;
    chk(ready_n_out, 1'b0);
    fork
      rdchk(3, q[0]);
      begin
        #3000;
        repeat (4) push;
        @(negedge clk);
        chk(conv_ready, 1'b0);
        push;
      end
    join
    wait_ready;
    rdchk(3, q[q.size() - 1]);
    @(posedge clk);
    upstream_ready_n_in <= 1'b1;
    push;
    repeat (40) @(posedge clk);
    chk(ready_n_out, 1'b1);
    @(posedge clk);
    upstream_ready_n_in <= 1'b0;
    wr(2, 96'h40);
    repeat (4) @(posedge clk);
    chk({config_out, rate_out}, 24'h400000);
    rdchk(0, 96'h0);
    wrap_up;
  end
endmodule // tb_top
